// ### bench/chtr_host.sv
// Host model for the charger register bank: issues single-byte accesses.
// Assumes the bench clock; each strobe lasts one cycle.
`timescale 1ns/100ps
module chtr_host (
    // Clock.
    input wire logic clock,
    // Register port.
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // One byte write (w=1) or read (w=0); strobes release low, address and data show the inverse.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : acc
endmodule : chtr_host

// ### bench/chtr_regs_tb.sv
// Self-checking bench for the charger register bank.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
module chtr_regs_tb;
    import chtr_pkg::*;
    localparam logic [7:0] TBL [6] = '{8'h9C, 8'h7C, 8'hFF, 8'h78, 8'h00, 8'h83};
    logic clock, rst_b, clk_en, reg_wr, reg_rd, sensor_open_in, factory_open_stop_enable, current_set_resistor_pin_grounded;
    logic charge_status_event, event_out, pend;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, current_set_resistor_pin_default, factory_default, v, e;
    logic [1:0] temp_code_in;
    logic [2:0] src;
    logic [8:0] external_current_ma;
    logic [5:0] termination_code;
    chtr_ctrl_s ctrl;
    int bad_count, samples_checked;
    logic [7:0] exp_q [$];
    chtr_host h (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    chtr_regs uut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .temp_code_in(temp_code_in),
        .sensor_open_in(sensor_open_in), .factory_open_stop_enable(factory_open_stop_enable),
        .current_set_resistor_pin_grounded(current_set_resistor_pin_grounded), .current_set_resistor_pin_default(current_set_resistor_pin_default), .factory_default(factory_default),
        .external_current_ma(external_current_ma), .wake_event(src[2]), .reset_event(src[1]),
        .timer_fault(src[0]), .charge_status_event(charge_status_event), .event_out(event_out),
        .ctrl(ctrl), .termination_code(termination_code));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        h.acc(1'b1, a, d);
        tick(2);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        h.acc(1'b0, a, 8'h00);
    endtask : rd
    task automatic do_reset();
        @(posedge clock);
        rst_b <= 1'b0;
        tick(3);
        chk(reg_rdata, 8'hFF);
        chk({event_out, ctrl.charge_enable}, 2'b00);
        chk(termination_code, 6'b000011);
        @(posedge clock);
        rst_b <= 1'b1;
        tick(2);
    endtask : do_reset
    // Read results are compared one cycle after each read edge.
    always @(posedge clock) begin
        if (pend && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
        pend <= reg_rd & rst_b;
    end
    initial begin
        #100us;
        bad_count++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, pend, sensor_open_in, factory_open_stop_enable, current_set_resistor_pin_grounded, charge_status_event} = '0;
        {clk_en, src, temp_code_in, bad_count, samples_checked} = '0;
        clk_en = 1'b1;
        current_set_resistor_pin_default = 8'h14;
        factory_default = 8'hA4;
        void'($urandom(32'h2df8));
        external_current_ma = 9'($urandom);
        do_reset();
        rd(8'h05, 8'hFF);
        rd(8'h00, 8'hFF);
        rd(OFS_TERM, 8'h0E);
        for (int t = 0; t < 4; t++) begin
            @(posedge clock);
            temp_code_in <= 2'(t);
            tick(3);
            chk({ctrl.thermal_qualify, ctrl.suspend, ctrl.current_halve, ctrl.voltage_lower},
                {1'b1, t == 1, t == 2, t == 3});
            rd(OFS_THERMAL, {1'b1, 2'(t), 5'h08});
        end
        wr(OFS_THERMAL, 8'h7F);
        rd(OFS_THERMAL, 8'h0F);
        chk({ctrl.thermal_qualify, ctrl.voltage_lower}, 2'b00);
        wr(OFS_TERM, 8'h04);
        chk(termination_code, 6'b000001);
        for (int i = 0; i < 12; i++) begin
            v = (i < 6) ? TBL[i] : 8'($urandom);
            e = v;
            if (v[6:2] != CODE_EXT && v[6:2] > (v[7] ? MAX_CODE_HI : MAX_CODE_LO))
                e[6:2] = v[7] ? MAX_CODE_HI : MAX_CODE_LO;
            wr(OFS_FAST, v);
            chk(ctrl.use_external_current, e[6:2] == CODE_EXT);
            chk(ctrl.charge_current_ma, (e[6:2] == CODE_EXT) ? external_current_ma
                : (e[7] ? 9'd40 + 9'(e[6:2]) * 9'd10 : 9'd5 + 9'(e[6:2])));
            chk({ctrl.charge_enable, ctrl.input_high_impedance}, {~e[1], e[0]});
            rd(OFS_FAST, e);
        end
        @(posedge clock);
        temp_code_in <= 2'b00;
        wr(OFS_THERMAL, 8'h80);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            src <= 3'b100 >> i;
            tick(3);
            chk(event_out, 1'b1);
            wr(OFS_THERMAL, 8'h80 | (8'h04 >> i));
            chk(event_out, 1'b0);
        end
        @(posedge clock);
        src <= 3'b000;
        charge_status_event <= 1'b1;
        wr(OFS_THERMAL, 8'h80);
        chk(event_out, 1'b0);
        wr(OFS_THERMAL, 8'h88);
        chk(event_out, 1'b1);
        @(posedge clock);
        charge_status_event <= 1'b0;
        sensor_open_in <= 1'b1;
        tick(3);
        chk({event_out, ctrl.charge_stop}, 2'b10);
        rd(OFS_THERMAL, 8'h98);
        @(posedge clock);
        factory_open_stop_enable <= 1'b1;
        current_set_resistor_pin_grounded <= 1'b1;
        tick(3);
        chk(ctrl.charge_stop, 1'b1);
        do_reset();
        rd(OFS_FAST, 8'hA4);
        chk(ctrl.charge_current_ma, 9'd130);
        tick(2);
        give_verdict();
    end
endmodule : chtr_regs_tb

// ### hdl/chtr_pkg.sv
// Constants and carriers for the charger thermal and current register bank.
// Assumes a serial engine outside that turns bus transfers into byte accesses.
package chtr_pkg;
    // Register offsets.
    localparam logic [7:0] OFS_THERMAL = 8'h02;
    localparam logic [7:0] OFS_FAST = 8'h03;
    localparam logic [7:0] OFS_TERM = 8'h04;
    localparam logic [7:0] RD_UNMAPPED = 8'hFF;
    // Reset values.
    localparam logic [7:0] RST_THERMAL = 8'h88;
    localparam logic [7:0] RST_FAST = 8'h14;
    localparam logic [7:0] RST_TERM = 8'h0E;
    // Field positions of the thermal register.
    localparam int B_THERMAL_SENSE_ENABLE = 7;
    localparam int B_TS_HI = 6;
    localparam int B_TS_LO = 5;
    localparam int B_OPEN = 4;
    localparam int B_EVT_FN = 3;
    localparam int B_WAKE_M = 2;
    localparam int B_RST_M = 1;
    localparam int B_TMR_M = 0;
    // Field positions of the fast charge register.
    localparam int B_RANGE = 7;
    localparam int B_CODE_HI = 6;
    localparam int B_CODE_LO = 2;
    localparam int B_DISABLE = 1;
    localparam int B_HIZ = 0;
    // Current arithmetic in mA.
    localparam logic [8:0] BASE_LO_MA = 9'd5;
    localparam logic [8:0] BASE_HI_MA = 9'd40;
    localparam logic [8:0] STEP_HI_MA = 9'd10;
    localparam logic [4:0] MAX_CODE_LO = 5'd30;
    localparam logic [4:0] MAX_CODE_HI = 5'd26;
    localparam logic [4:0] CODE_EXT = 5'h1F;
    // Temperature status codes.
    typedef enum logic [1:0] {
        CHTR_TS_OK = 2'b00, CHTR_TS_SUSPEND = 2'b01, CHTR_TS_COOL = 2'b10, CHTR_TS_WARM = 2'b11
    } chtr_temp_e;
    // Start-up phase, one-hot.
    typedef enum logic [1:0] {CHTR_LOAD = 2'b01, CHTR_RUN = 2'b10} chtr_phase_e;
    // Loop controls handed to the analog side.
    typedef struct packed {
        logic charge_enable;
        logic input_high_impedance;
        logic thermal_qualify;
        logic suspend;
        logic current_halve;
        logic voltage_lower;
        logic charge_stop;
        logic use_external_current;
        logic [8:0] charge_current_ma;
    } chtr_ctrl_s;
    // Whole state of the bank.
    typedef struct packed {
        chtr_phase_e phase;
        logic [7:0] thermal;
        logic [7:0] fast;
        logic [7:0] term;
        logic [7:0] rdata;
        logic event_out;
        chtr_ctrl_s ctrl;
    } chtr_state_s;
endpackage : chtr_pkg

// ### hdl/chtr_regs.sv
// Charger thermal, event mask and fast-charge current register bank.
// Assumes byte accesses from a serial engine, synchronous to clock.
// Operation
// - Sense enable bit gates temperature qualification.
// - Two-bit temperature status with four meanings.
// - Open sensor flag, stop if factory enabled.
// - Event function bit adds charge status.
// - Mask bits suppress wake, reset, timer events.
// - Range bit selects 5 or 40 mA base.
// - Current is base plus code times step.
// - Oversized codes clamp to 35 or 300 mA.
// - All-ones code selects external resistor current.
// - Disable bit turns charger off.
// - High impedance bit isolates the input.
// - Default current from resistor or factory memory.
// - Unmapped reads return all ones.
`timescale 1ns/100ps
module chtr_regs import chtr_pkg::*; (
    // Clock, reset and enable.
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // Byte register port.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Detection and strap inputs.
    input wire logic [1:0] temp_code_in,
    input wire logic sensor_open_in,
    input wire logic factory_open_stop_enable,
    input wire logic current_set_resistor_pin_grounded,
    input wire logic [7:0] current_set_resistor_pin_default,
    input wire logic [7:0] factory_default,
    input wire logic [8:0] external_current_ma,
    // Event sources.
    input wire logic wake_event,
    input wire logic reset_event,
    input wire logic timer_fault,
    input wire logic charge_status_event,
    // Outputs.
    output logic event_out,
    output chtr_ctrl_s ctrl,
    output logic [5:0] termination_code
);
    ////////////////////////////////////////////////////////////////////////////
    chtr_state_s state;
    chtr_state_s next_state;
    logic [1:0] temp_seen;
    logic fault_any;

    function automatic logic [7:0] clamp_fast(input logic [7:0] v);
        logic [4:0] c;
        logic [7:0] r;
        c = v[B_CODE_HI:B_CODE_LO];
        r = v;
        if (c != CODE_EXT && !v[B_RANGE] && c > MAX_CODE_LO) begin
            r[B_CODE_HI:B_CODE_LO] = MAX_CODE_LO;
        end else if (c != CODE_EXT && v[B_RANGE] && c > MAX_CODE_HI) begin
            r[B_CODE_HI:B_CODE_LO] = MAX_CODE_HI;
        end
        return r;
    endfunction : clamp_fast

    ////////////////////////////////////////////////////////////////////////////
    // gated status code.
    assign temp_seen = state.thermal[B_THERMAL_SENSE_ENABLE] ? temp_code_in : CHTR_TS_OK;
    assign fault_any = (temp_seen != CHTR_TS_OK) || sensor_open_in
        || (wake_event && !state.thermal[B_WAKE_M])
        || (reset_event && !state.thermal[B_RST_M])
        || (timer_fault && !state.thermal[B_TMR_M]);

    always_comb begin
        logic [4:0] code;
        code = 5'd0;
        next_state = state;
        if (clk_en) begin
            case (state.phase)
                CHTR_LOAD: begin
                    next_state.fast = clamp_fast(current_set_resistor_pin_grounded ? factory_default : current_set_resistor_pin_default);
                    next_state.phase = CHTR_RUN;
                end
                CHTR_RUN: begin
                    if (reg_wr) begin
                        case (reg_addr)
                            OFS_THERMAL: begin
                                next_state.thermal[B_THERMAL_SENSE_ENABLE] = reg_wdata[B_THERMAL_SENSE_ENABLE];
                                next_state.thermal[B_EVT_FN:B_TMR_M] = reg_wdata[B_EVT_FN:B_TMR_M];
                            end
                            OFS_FAST: next_state.fast = clamp_fast(reg_wdata);
                            OFS_TERM: next_state.term = reg_wdata;
                            default: next_state.phase = CHTR_RUN;
                        endcase
                    end
                end
                default: next_state.phase = CHTR_LOAD;
            endcase
            if (reg_rd) begin
                case (reg_addr)
                    OFS_THERMAL: begin
                        next_state.rdata = state.thermal;
                        next_state.rdata[B_TS_HI:B_TS_LO] = temp_seen;
                        next_state.rdata[B_OPEN] = sensor_open_in;
                    end
                    OFS_FAST: next_state.rdata = state.fast;
                    OFS_TERM: next_state.rdata = state.term;
                    default: next_state.rdata = RD_UNMAPPED;
                endcase
            end
            next_state.event_out = fault_any || (state.thermal[B_EVT_FN] && charge_status_event);
            code = state.fast[B_CODE_HI:B_CODE_LO];
            next_state.ctrl.charge_enable = !state.fast[B_DISABLE];
            next_state.ctrl.input_high_impedance = state.fast[B_HIZ];
            next_state.ctrl.thermal_qualify = state.thermal[B_THERMAL_SENSE_ENABLE];
            next_state.ctrl.suspend = temp_seen == CHTR_TS_SUSPEND;
            next_state.ctrl.current_halve = temp_seen == CHTR_TS_COOL;
            next_state.ctrl.voltage_lower = temp_seen == CHTR_TS_WARM;
            next_state.ctrl.charge_stop = sensor_open_in && factory_open_stop_enable;
            next_state.ctrl.use_external_current = code == CODE_EXT;
            if (code == CODE_EXT) begin
                next_state.ctrl.charge_current_ma = external_current_ma;
            end else if (state.fast[B_RANGE]) begin
                next_state.ctrl.charge_current_ma = 9'(BASE_HI_MA + 9'(code) * STEP_HI_MA);
            end else begin
                next_state.ctrl.charge_current_ma = 9'(BASE_LO_MA + 9'(code));
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{phase: CHTR_LOAD, thermal: RST_THERMAL, fast: RST_FAST, term: RST_TERM,
                       rdata: RD_UNMAPPED, event_out: 1'b0, ctrl: '0};
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign event_out = state.event_out;
    assign ctrl = state.ctrl;
    // termination code for the analog side.
    assign termination_code = state.term[B_RANGE:B_CODE_LO];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sense_gate_a: assert property (clk_en && !state.thermal[B_THERMAL_SENSE_ENABLE] |=> !ctrl.suspend && !ctrl.current_halve)
        else $error("Temperature action while sensing disabled.");
    temp_code_a: assert property (clk_en && state.thermal[B_THERMAL_SENSE_ENABLE] && temp_code_in == CHTR_TS_WARM
        |=> ctrl.voltage_lower && !ctrl.suspend)
        else $error("Warm code did not lower voltage.");
    open_stop_a: assert property (clk_en && sensor_open_in && factory_open_stop_enable |=> ctrl.charge_stop)
        else $error("Open sensor did not stop charge.");
    event_fn_a: assert property (clk_en && !fault_any && charge_status_event
        |=> event_out == $past(state.thermal[B_EVT_FN]))
        else $error("Charge status event not gated by function bit.");
    mask_wake_a: assert property (clk_en && state.thermal[B_WAKE_M] && wake_event && !sensor_open_in
        && temp_seen == CHTR_TS_OK && !reset_event && !timer_fault && !charge_status_event |=> !event_out)
        else $error("Masked wake raised an event.");
    lo_range_a: assert property (clk_en && !state.fast[B_RANGE] && state.fast[B_CODE_HI:B_CODE_LO] != CODE_EXT
        |=> ctrl.charge_current_ma <= 9'd35 && ctrl.charge_current_ma >= BASE_LO_MA)
        else $error("Low range current out of bounds.");
    clamp_wr_a: assert property (clk_en && state.phase == CHTR_RUN && reg_wr && reg_addr == OFS_FAST
        && reg_wdata[B_RANGE] && reg_wdata[B_CODE_HI:B_CODE_LO] == 5'd30 |=> state.fast[B_CODE_HI:B_CODE_LO] == 5'd26)
        else $error("High range code not clamped.");
    hi_range_a: assert property (clk_en && state.fast[B_RANGE] && state.fast[B_CODE_HI:B_CODE_LO] != CODE_EXT
        |=> ctrl.charge_current_ma <= 9'd300 && ctrl.charge_current_ma >= BASE_HI_MA)
        else $error("High range current out of bounds.");
    ext_sel_a: assert property (clk_en && state.fast[B_CODE_HI:B_CODE_LO] == CODE_EXT
        |=> ctrl.use_external_current && ctrl.charge_current_ma == $past(external_current_ma))
        else $error("External current not selected.");
    disable_a: assert property (clk_en && state.fast[B_DISABLE] |=> !ctrl.charge_enable)
        else $error("Charger not disabled.");
    hiz_a: assert property (clk_en && state.fast[B_HIZ] |=> ctrl.input_high_impedance)
        else $error("Input not high impedance.");
    unmapped_a: assert property (clk_en && reg_rd && reg_addr > OFS_TERM |=> reg_rdata == RD_UNMAPPED)
        else $error("Unmapped read not all ones.");
    ro_bits_a: assert property (clk_en && reg_wr && reg_addr == OFS_THERMAL
        |=> state.thermal[B_TS_HI:B_OPEN] == $past(state.thermal[B_TS_HI:B_OPEN]))
        else $error("Read-only bits were written.");
    startup_a: assert property ($rose(rst_b) ##0 clk_en |=> state.phase == CHTR_RUN)
        else $error("Default load did not finish.");

    ext_seen_c: cover property (ctrl.use_external_current);
    hi_clamp_c: cover property (ctrl.charge_current_ma == 9'd300);
    unmapped_c: cover property (reg_rd && reg_addr == 8'h10);
    event_c: cover property (event_out && state.thermal[B_EVT_FN]);
    open_stop_c: cover property (ctrl.charge_stop);
endmodule : chtr_regs
